/* File: logic/sfp_pkg.sv */
// Purpose: Shared constants for the serial flash pin interface front end.
// Assumes: The system clock samples every serial pin through a three-stage synchroniser.
// Notes: Opcode values are the ones that the command decoder accepts.
package sfp_pkg;
   localparam int SFP_BYTE_W = 8;             // Bits in one serial byte.
   localparam int SFP_SYNC_STAGES = 3;        // Flops on each pin input.
   localparam logic [2:0] SFP_BITCNT_RST = 3'h0;  // Bit counter value after reset.
   localparam logic [7:0] SFP_BYTE_RST = 8'h00;   // Shift register value after reset.
   localparam logic [1:0] SFP_ABYTES = 2'h3;      // Address bytes after an opcode.
   localparam int SFP_FIFO_DEPTH = 8;         // Received byte buffer depth.
   // Supported opcodes; anything else makes the frame be ignored.
   localparam logic [7:0] SFP_OP_RD_FAST = 8'h0B;
   localparam logic [7:0] SFP_OP_RD = 8'h03;
   localparam logic [7:0] SFP_OP_ERASE4 = 8'h20;
   localparam logic [7:0] SFP_OP_ERASE32A = 8'h52;
   localparam logic [7:0] SFP_OP_ERASE32B = 8'hD8;
   localparam logic [7:0] SFP_OP_CHIPA = 8'h60;
   localparam logic [7:0] SFP_OP_CHIPB = 8'hC7;
   localparam logic [7:0] SFP_OP_CHIPC = 8'h62;
   localparam logic [7:0] SFP_OP_PROG = 8'h02;
   localparam logic [7:0] SFP_OP_WREN = 8'h06;
   localparam logic [7:0] SFP_OP_WRDI = 8'h04;
   localparam logic [7:0] SFP_OP_OTPP = 8'h9B;
   localparam logic [7:0] SFP_OP_OTPR = 8'h77;
   localparam logic [7:0] SFP_OP_RDSR = 8'h05;
   localparam logic [7:0] SFP_OP_WRSR = 8'h01;
   // Frame state of the receiver.
   typedef enum logic [1:0] {SFP_IDLE, SFP_ACTIVE, SFP_IGNORE} sfp_state_t;
endpackage

/* File: logic/sfp_top.sv */
// Purpose: Pin front end of a serial flash: framing, edge sampling, hold, output enable.
// Assumes: clk is much faster than the serial clock; pins are asynchronous to clk.
// Notes: Received bytes leave through a small FIFO towards the command decoder.
// Behaviour
// [RULE_01] Deselect enters standby, output goes high impedance.
// [RULE_02] Serial input ignored while deselected.
// [RULE_03] Select falling starts, rising ends operations.
// [RULE_04] Busy internal cycle blocks standby until done.
// [RULE_05] Sample input on serial clock rising edges.
// [RULE_06] Change output on serial clock falling edges.
// [RULE_07] Low write protect asserts hardware lock.
// [RULE_08] Hold pauses transfer, keeps state for resuming.
// [RULE_09] Hold ignores clock, input; output high impedance.
// [RULE_10] Hold begins only selected with clock low.
// [RULE_11] Hold leaves internal program/erase cycles running.
// [RULE_12] Opcode then address/data, all MSB first.
// [RULE_13] Unsupported opcode ignored until next selection.
// [RULE_14] Early deselect performs no operation, idle.
// [RULE_15] Works in clock modes 0 and 3.
// [RULE_16] Deselect clears bit counter and partial byte.
`timescale 1ns/100ps

// Synchronous FIFO in flip-flops with valid/ready on both sides.
module sfp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];   // Storage words.
   logic [AW-1:0] wr_r;               // Write index.
   logic [AW-1:0] rd_r;               // Read index.
   logic [AW:0] cnt_r;                // Words held.
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // The count is one bit wider than the index, so a full buffer of DEPTH words is told apart.
   assign in_ready = cnt_r < (AW+1)'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem_r[rd_r];

   // Indices wrap at DEPTH, so a non power of two depth also works.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            mem_r[wr_r] <= in_data;
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sfp_fifo

// Three-flop pin synchroniser; a change counts when stages two and three agree.
module sfp_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic pin,
   output logic level
);
   logic s1_r;   // Metastability catcher, read only by s2_r.
   logic s2_r;   // Second stage.
   logic s3_r;   // Third stage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
         level <= INIT;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level <= s3_r;
         end
      end
   end
endmodule // sfp_sync

module sfp_top #(
   parameter int FIFO_DEPTH = sfp_pkg::SFP_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic wp_n,
   input wire logic hold_n,
   input wire logic busy,
   input wire logic tx_bit,
   output logic tx_shift,
   output logic [sfp_pkg::SFP_BYTE_W-1:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_opcode,
   output logic frame_active,
   output logic frame_abort,
   output logic frame_end,
   output logic hw_lock,
   output logic standby,
   output logic rx_overflow
);
   import sfp_pkg::*;

   logic cs_n_q;    // Filtered select.
   logic sck_q;     // Filtered serial clock.
   logic si_q;      // Filtered serial input.
   logic wp_n_q;    // Filtered write protect.
   logic hold_n_q;  // Filtered hold.
   sfp_sync #(.INIT(1'b1)) u_cs (.clk(clk), .reset_n(reset_n), .pin(cs_n), .level(cs_n_q));
   sfp_sync #(.INIT(1'b0)) u_sck (.clk(clk), .reset_n(reset_n), .pin(sck), .level(sck_q));
   sfp_sync #(.INIT(1'b0)) u_si (.clk(clk), .reset_n(reset_n), .pin(si), .level(si_q));
   sfp_sync #(.INIT(1'b1)) u_wp (.clk(clk), .reset_n(reset_n), .pin(wp_n), .level(wp_n_q));
   sfp_sync #(.INIT(1'b1)) u_hold (.clk(clk), .reset_n(reset_n), .pin(hold_n), .level(hold_n_q));

   sfp_state_t state_r;                 // Frame state.
   sfp_state_t state_nxt;
   logic cs_n_d_r;                      // Previous select level.
   logic sck_d_r;                       // Previous serial clock level.
   logic hold_r;                        // Hold condition in force.
   logic [2:0] bitcnt_r;                // Bits of current byte received.
   logic [SFP_BYTE_W-1:0] shreg_r;      // Partial byte, MSB first.
   logic [1:0] addr_left_r;             // Address bytes still owed.
   logic first_r;                       // Next byte is the opcode.
   logic so_r;                          // Output bit register.
   logic oe_r;                          // Output drive enable register.
   logic end_r;                         // Frame end pulse register.
   logic abort_r;                       // Early deselect pulse register.
   logic ovf_r;                         // Sticky FIFO overflow.

   // Mode 0 and 3 differ only in idle clock level; edges are treated alike. [RULE_15]
   wire cs_fall = cs_n_d_r && !cs_n_q;         // [RULE_03]
   wire cs_rise = !cs_n_d_r && cs_n_q;         // [RULE_03]
   wire sck_rise = !sck_d_r && sck_q;
   wire sck_fall = sck_d_r && !sck_q;
   // Hold starts only while selected with the clock low; it ends on hold release or deselect. [RULE_10]
   wire hold_nxt = hold_r ? !hold_n_q && !cs_n_q : !hold_n_q && !cs_n_q && !sck_q;
   wire link_on = (state_r == SFP_ACTIVE) && !hold_r;        // [RULE_02] [RULE_09]
   wire sample = link_on && sck_rise;                        // [RULE_05]
   wire [SFP_BYTE_W-1:0] byte_now = {shreg_r[SFP_BYTE_W-2:0], si_q};   // [RULE_12]
   wire byte_done = sample && (bitcnt_r == 3'h7);
   wire op_known = (byte_now == SFP_OP_RD_FAST) || (byte_now == SFP_OP_RD)
      || (byte_now == SFP_OP_ERASE4) || (byte_now == SFP_OP_ERASE32A)
      || (byte_now == SFP_OP_ERASE32B) || (byte_now == SFP_OP_CHIPA)
      || (byte_now == SFP_OP_CHIPB) || (byte_now == SFP_OP_CHIPC)
      || (byte_now == SFP_OP_PROG) || (byte_now == SFP_OP_WREN)
      || (byte_now == SFP_OP_WRDI) || (byte_now == SFP_OP_OTPP)
      || (byte_now == SFP_OP_OTPR) || (byte_now == SFP_OP_RDSR)
      || (byte_now == SFP_OP_WRSR);
   wire op_addr = (byte_now == SFP_OP_RD_FAST) || (byte_now == SFP_OP_RD)
      || (byte_now == SFP_OP_ERASE4) || (byte_now == SFP_OP_ERASE32A)
      || (byte_now == SFP_OP_ERASE32B) || (byte_now == SFP_OP_PROG)
      || (byte_now == SFP_OP_OTPP) || (byte_now == SFP_OP_OTPR);
   wire bad_op = byte_done && first_r && !op_known;          // [RULE_13]
   wire push = byte_done && !bad_op;
   wire fifo_ready;
   // Deselect before opcode and address are complete yields no operation. [RULE_14]
   wire early = cs_rise && (state_r == SFP_ACTIVE) && (first_r || addr_left_r != 2'h0);

   sfp_fifo #(.WIDTH(SFP_BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(byte_now),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // Next frame state from select edges and the opcode check.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SFP_IDLE: if (cs_fall) state_nxt = SFP_ACTIVE;                  // [RULE_03]
         SFP_ACTIVE: begin
            if (cs_n_q) state_nxt = SFP_IDLE;                            // [RULE_01]
            else if (bad_op) state_nxt = SFP_IGNORE;                     // [RULE_13]
         end
         SFP_IGNORE: if (cs_n_q) state_nxt = SFP_IDLE;                   // [RULE_13]
         // The unused code falls back to idle.
         default: state_nxt = SFP_IDLE;
      endcase
   end

   // Frame, hold and receive registers. Hold freezes the bit counter, partial byte and address tracking in place. [RULE_08]
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= SFP_IDLE;
         cs_n_d_r <= 1'b1;
         sck_d_r <= 1'b0;
         hold_r <= 1'b0;
         bitcnt_r <= SFP_BITCNT_RST;
         shreg_r <= SFP_BYTE_RST;
         addr_left_r <= 2'h0;
         first_r <= 1'b1;
         end_r <= 1'b0;
         abort_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cs_n_d_r <= cs_n_q;
         sck_d_r <= sck_q;
         hold_r <= hold_nxt;
         end_r <= cs_rise;
         abort_r <= early;
         if (push && !fifo_ready) ovf_r <= 1'b1;
         if (cs_n_q) begin
            bitcnt_r <= SFP_BITCNT_RST;                                   // [RULE_16]
            shreg_r <= SFP_BYTE_RST;                                      // [RULE_16]
            first_r <= 1'b1;
            addr_left_r <= 2'h0;
         end else if (sample) begin
            bitcnt_r <= bitcnt_r + 3'h1;
            shreg_r <= byte_now;                                          // [RULE_05]
            if (byte_done) begin
               first_r <= 1'b0;
               if (first_r) addr_left_r <= op_addr ? SFP_ABYTES : 2'h0;
               else if (addr_left_r != 2'h0) addr_left_r <= addr_left_r - 2'h1;
            end
         end
      end
   end

   // Output bit moves only on falling clock edges; drive only when selected, not held.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         so_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         oe_r <= link_on && !cs_n_q && !hold_nxt;                         // [RULE_01] [RULE_09]
         if (link_on && sck_fall) so_r <= tx_bit;                         // [RULE_06]
      end
   end

   assign so = so_r;
   assign so_oe = oe_r;
   assign tx_shift = link_on && sck_fall;                                 // [RULE_06]
   assign rx_opcode = push && first_r;
   assign frame_active = state_r != SFP_IDLE;
   assign frame_end = end_r;
   assign frame_abort = abort_r;
   assign rx_overflow = ovf_r;
   // Low write protect raises the lock; the pin floats high when unused. [RULE_07]
   assign hw_lock = !wp_n_q;
   // Standby waits for the internal cycle; hold never touches busy. [RULE_04] [RULE_11]
   assign standby = (state_r == SFP_IDLE) && !busy;                       // [RULE_01]
endmodule // sfp_top

/* File: tb/sfp_top_asserts.sv */
// Purpose: Port-level checks of the serial flash pin front end.
// Assumes: Synchroniser lag is at most four clk cycles.
// Notes: Pin relations get six cycles to settle.
`timescale 1ns/100ps
module sfp_top_asserts #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic wp_n,
   input wire logic hold_n,
   input wire logic busy,
   input wire logic so_oe,
   input wire logic tx_shift,
   input wire logic rx_opcode,
   input wire logic frame_active,
   input wire logic frame_end,
   input wire logic hw_lock,
   input wire logic standby
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_oe_desel; cs_n [*6] |-> !so_oe; endproperty
   a_oe_desel: assert property (p_oe_desel) else $error("so_oe high when deselected");
   property p_busy; busy |-> !standby; endproperty
   a_busy: assert property (p_busy) else $error("standby while busy");
   property p_lock; (!wp_n) [*6] |-> hw_lock; endproperty
   a_lock: assert property (p_lock) else $error("lock missing");
   property p_unlock; wp_n [*6] |-> !hw_lock; endproperty
   a_unlock: assert property (p_unlock) else $error("lock stuck");
   property p_hold_oe; (!hold_n) [*6] |-> !so_oe; endproperty
   a_hold_oe: assert property (p_hold_oe) else $error("so_oe high in hold");
   property p_hold_sh; (!hold_n) [*6] |-> !tx_shift; endproperty
   a_hold_sh: assert property (p_hold_sh) else $error("shift in hold");
   property p_end; $rose(cs_n) && frame_active |-> ##[2:6] frame_end; endproperty
   a_end: assert property (p_end) else $error("no frame end");
   property p_pulse; frame_end |=> !frame_end; endproperty
   a_pulse: assert property (p_pulse) else $error("frame end too long");
   property p_idle_rx; !frame_active |-> !rx_opcode; endproperty
   a_idle_rx: assert property (p_idle_rx) else $error("byte taken when idle");
endmodule // sfp_top_asserts
bind sfp_top sfp_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk(clk), .reset_n(reset_n),
   .cs_n(cs_n), .wp_n(wp_n), .hold_n(hold_n), .busy(busy), .so_oe(so_oe), .tx_shift(tx_shift),
   .rx_opcode(rx_opcode), .frame_active(frame_active), .frame_end(frame_end),
   .hw_lock(hw_lock), .standby(standby));

/* File: tb/sfp_host_model.sv */
// Purpose: Host side serial master, modes 0 and 3.
// Assumes: Half period of the serial clock is four clk cycles.
// Notes: Released data line shows the inverse of its last value.
`timescale 1ns/100ps
module sfp_host_model (
   input wire logic clk,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n
);
   logic idle_lvl = 1'b0;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Clock parks at the mode's idle level before select falls.
   task automatic start(input bit m3);
      idle_lvl = m3;
      sck = m3;
      half();
      cs_n = 1'b0;
      half();
   endtask
   // Data changes while the clock is low, MSB first.
   task automatic bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         sck = 1'b0;
         si = b[7-i];
         half();
         sck = 1'b1;
         half();
      end
   endtask
   task automatic stop();
      sck = idle_lvl;
      half();
      cs_n = 1'b1;
      si = ~si;
      half();
      half();
   endtask
   // Hold only starts selected with the clock low; junk is clocked meanwhile.
   task automatic pause(input int n);
      sck = 1'b0;
      half();
      hold_n = 1'b0;
      half();
      repeat (2 * n) begin
         sck = ~sck;
         si = ~si;
         half();
      end
      hold_n = 1'b1;
      half();
   endtask
endmodule // sfp_host_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench of the pin front end.
// Assumes: Host model timing and a 25 MHz clk.
// Notes: Pops are stalled at random.
`timescale 1ns/100ps
module tb;
   import sfp_pkg::*;
   logic clk, reset_n, cs_n, sck, si, so, so_oe, wp_n, hold_n, busy, tx_bit, tx_shift;
   logic [7:0] rx_data;
   logic rx_valid, rx_ready, rx_opcode, frame_active, frame_abort, frame_end;
   logic hw_lock, standby, rx_overflow, stall;
   logic so_exp = 1'b0;
   int failures, tests_run, cycles, aborts;
   logic [7:0] exp_q[$];
   logic [7:0] got_q[$];
   logic [7:0] ops[15] = '{SFP_OP_RD_FAST, SFP_OP_RD, SFP_OP_ERASE4, SFP_OP_ERASE32A,
      SFP_OP_ERASE32B, SFP_OP_CHIPA, SFP_OP_CHIPB, SFP_OP_CHIPC, SFP_OP_PROG, SFP_OP_WREN,
      SFP_OP_WRDI, SFP_OP_OTPP, SFP_OP_OTPR, SFP_OP_RDSR, SFP_OP_WRSR};
   sfp_top #(.FIFO_DEPTH(8)) i_dut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
      .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n), .busy(busy),
      .tx_bit(tx_bit), .tx_shift(tx_shift), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_opcode(rx_opcode), .frame_active(frame_active),
      .frame_abort(frame_abort), .frame_end(frame_end), .hw_lock(hw_lock),
      .standby(standby), .rx_overflow(rx_overflow));
   sfp_host_model i_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Counts cycles and cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         tally_and_finish();
      end
   end
   // Records popped bytes and aborts; follows the bit that the output must show.
   always @(posedge clk) begin
      if (rx_valid && rx_ready) got_q.push_back(rx_data);
      if (frame_abort) aborts++;
      if (so_oe) check("so", {7'h0, so}, {7'h0, so_exp});
      if (tx_shift) so_exp = tx_bit;
      #1;
      rx_ready = stall ? 1'b0 : 1'($urandom_range(1));
      tx_bit = 1'($urandom_range(1));
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic bit known_op(input logic [7:0] op);
      foreach (ops[i]) if (ops[i] == op) return 1'b1;
      return 1'b0;
   endfunction
   task automatic frame(input bit m3, input logic [7:0] op, input int nb);
      logic [7:0] b;
      i_host.start(m3);
      i_host.bits(op, 8);
      if (known_op(op)) exp_q.push_back(op);
      for (int i = 0; i < nb; i++) begin
         b = 8'($urandom);
         i_host.bits(b, 8);
         if (known_op(op)) exp_q.push_back(b);
      end
      i_host.stop();
   endtask
   task automatic drain_cmp();
      int n;
      n = 0;
      while (rx_valid !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      #2;
      check("count", 8'(got_q.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) if (i < got_q.size()) check("byte", got_q[i], exp_q[i]);
      check("standby", {7'h0, standby}, {7'h0, !busy});
      check("lock", {7'h0, hw_lock}, {7'h0, !wp_n});
      check("active", {7'h0, frame_active}, 8'h00);
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hF683));
      {reset_n, busy, stall} = 3'h0;
      wp_n = 1'b1;
      repeat (8) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (5) @(posedge clk);
      foreach (ops[i]) begin
         wp_n = 1'($urandom_range(1));
         busy = 1'($urandom_range(1));
         frame(i % 2, ops[i], 3);
         drain_cmp();
      end
      busy = 1'b0;
      frame(0, 8'hFF, 4);
      drain_cmp();
      i_host.start(0);
      i_host.bits(8'hA5, 3);
      i_host.stop();
      frame(1, SFP_OP_RD, 3);
      drain_cmp();
      aborts = 0;
      frame(0, SFP_OP_PROG, 1);
      drain_cmp();
      check("abort", 8'(aborts), 8'h01);
      exp_q = '{SFP_OP_RD, 8'h3C};
      i_host.start(0);
      i_host.bits(SFP_OP_RD, 8);
      i_host.bits(8'h30, 4);
      busy = 1'b1;
      i_host.pause(3);
      i_host.bits(8'hC0, 4);
      i_host.stop();
      drain_cmp();
      busy = 1'b0;
      stall = 1'b1;
      frame(0, SFP_OP_PROG, 9);
      exp_q = exp_q[0:7];
      check("overflow", {7'h0, rx_overflow}, 8'h01);
      stall = 1'b0;
      drain_cmp();
      tally_and_finish();
   end
endmodule // tb
